// file: rtl/vcomp_pkg.sv
// constants and carrier types for the dual voltage comparator control block
// assumes a single 20 MHz system clock and a 32-bit Avalon-MM register port
package vcomp_pkg;

   localparam int NUM_CH = 2;
   localparam int CODE_W = 4;
   localparam int NUM_W  = 5;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;

   // register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_CTRL0  = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_CTRL1  = 5'h04;
   localparam logic [ADDR_W-1:0] ADDR_RESULT = 5'h08;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h0c;
   localparam logic [ADDR_W-1:0] ADDR_MASK   = 5'h10;

   // result register layout: flags at 5:4, levels at 1:0
   localparam int FLAG_LSB  = 4;
   localparam int LEVEL_LSB = 0;

   localparam logic [7:0]        CTRL_RESET = 8'h00;
   localparam logic [DATA_W-1:0] READ_IDLE  = 32'h0;

   // reference numerators in thirtieths of supply: upper 11+n, lower 9+n
   localparam logic [NUM_W-1:0] UPPER_BASE = 5'h0b;
   localparam logic [NUM_W-1:0] LOWER_BASE = 5'h09;

   typedef struct packed {
      logic              run;
      logic              irq_en;
      logic              ref_ext;
      logic              hyst;
      logic [CODE_W-1:0] code;
   } ctrl_t;

   typedef struct packed {
      logic             run;
      logic             ref_ext;
      logic             hyst;
      logic [NUM_W-1:0] upper_num;
      logic [NUM_W-1:0] lower_num;
   } afe_ctrl_t;

   typedef struct packed {
      logic above_upper;
      logic above_lower;
      logic above_ext;
   } afe_sense_t;

   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic              read;
      logic              write;
      logic [DATA_W-1:0] writedata;
      logic [3:0]        byteenable;
   } avs_req_t;

endpackage

// file: rtl/sync2.sv
// two flip-flop synchroniser for asynchronous comparator decisions
// assumes inputs are quasi-static levels, not pulses
`timescale 1ns/1ps
module sync2
#(
   parameter int W = 1
)
(
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         srst,
   // level in and out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end
      else
      begin
         stage1_reg <= d;
         stage2_reg <= stage1_reg;
      end
   end

   assign q = stage2_reg;

   a_sync_two_stage: assert property (
      @(posedge mclk) disable iff (srst)
      !$past(srst) && !$past(srst, 2) |-> q == $past(d, 2))
      else $error("synchroniser output is not the input two cycles back");

endmodule

// file: rtl/vcomp_channel.sv
// one comparator channel: turns synchronised front-end decisions into a level
// assumes sense inputs already pass the synchroniser
`timescale 1ns/1ps
module vcomp_channel
(
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  srst,
   // control and sense
   input  wire vcomp_pkg::ctrl_t      ctrl,
   input  wire vcomp_pkg::afe_sense_t sense,
   // result
   output logic                       level_above
);
   import vcomp_pkg::*;

   logic level_reg;
   logic level_next;
   logic hyst_on;
   logic hyst_level;

   // the prohibited external+hysteresis combination falls back to plain external
   assign hyst_on    = ctrl.hyst & ~ctrl.ref_ext;
   assign hyst_level = sense.above_upper ? 1'b1 : (sense.above_lower & level_reg);
   assign level_next = !ctrl.run    ? 1'b0 :
                       ctrl.ref_ext ? sense.above_ext :
                       hyst_on      ? hyst_level :
                                      sense.above_upper;

   always_ff @(posedge mclk)
   begin
      if (srst)
         level_reg <= 1'b0;
      else
         level_reg <= level_next;
   end

   assign level_above = level_reg;

   a_halt_level_low: assert property (
      @(posedge mclk) disable iff (srst)
      !ctrl.run |=> !level_reg)
      else $error("halted channel shows a high level");

   a_ext_direct: assert property (
      @(posedge mclk) disable iff (srst)
      ctrl.run && ctrl.ref_ext |=> level_reg == $past(sense.above_ext))
      else $error("external reference result does not follow its comparator");

   a_single_level: assert property (
      @(posedge mclk) disable iff (srst)
      ctrl.run && !ctrl.ref_ext && !ctrl.hyst |=> level_reg == $past(sense.above_upper))
      else $error("plain internal result does not follow the upper level");

   a_hyst_hold: assert property (
      @(posedge mclk) disable iff (srst)
      ctrl.run && hyst_on && sense.above_lower && !sense.above_upper
      |=> $stable(level_reg))
      else $error("result moved inside the hysteresis band");

endmodule

// file: rtl/dual_voltage_comparator_ctrl.sv
// register and interrupt control for two voltage comparator channels
// assumes an analog front end that returns upper, lower and external decisions
// per channel asynchronously, and an Avalon-MM master on mclk
//
// Behaviour
// - two independent channels, each with its own comparator and control register
// - run bit 7 low halts the channel; it resets low
// - bit 6 gates the channel interrupt request; it resets low
// - bit 5 picks internal supply fraction or external reference pin
// - code n gives upper (11+n)/30 and lower (9+n)/30 of supply
// - threshold code is ignored with the external reference
// - internal reference without hysteresis compares against the upper level only
// - internal reference with hysteresis switches between upper and lower levels
// - external reference without hysteresis compares pin against reference pin
// - read-only result bit is high while input exceeds the reference
// - change flag sets on interrupt; read as one then write zero clears it
// - reading result with run and enable latches it; later difference interrupts
// - no interrupt during a result read; clearing enable disarms the latch
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module dual_voltage_comparator_ctrl
(
   // clock and reset
   input  wire logic                                       mclk,
   input  wire logic                                       srst,
   // register bus
   input  wire vcomp_pkg::avs_req_t                        bus_req,
   output logic      [vcomp_pkg::DATA_W-1:0]               readdata,
   output logic                                            waitrequest,
   // interrupt
   output logic                                            irq,
   // analog front end
   input  wire vcomp_pkg::afe_sense_t [vcomp_pkg::NUM_CH-1:0] sense_raw,
   output vcomp_pkg::afe_ctrl_t       [vcomp_pkg::NUM_CH-1:0] afe_ctrl
);
   import vcomp_pkg::*;

   localparam int SENSE_W = $bits(afe_sense_t) * NUM_CH;

   // bus handshake
   logic              waitreq_reg;
   logic              waitreq_next;
   logic [DATA_W-1:0] readdata_reg;
   logic [DATA_W-1:0] rd_mux;
   logic              req;
   logic              done;
   logic              rd_take;
   logic              wr_done;
   logic              lane0;

   // address decode
   logic              hit_ctrl0;
   logic              hit_ctrl1;
   logic              hit_result;
   logic              hit_status;
   logic              hit_mask;
   logic              rd_result;
   logic              rd_status;
   logic              wr_result;
   logic              wr_mask;
   logic [NUM_CH-1:0] wr_ctrl;

   // per channel state
   ctrl_t             ctrl_reg   [NUM_CH];
   ctrl_t             ctrl_next  [NUM_CH];
   afe_ctrl_t         afe_reg    [NUM_CH];
   afe_ctrl_t         afe_next   [NUM_CH];
   logic [CODE_W-1:0] code_w     [NUM_CH];
   afe_sense_t        sense_sync [NUM_CH];
   logic [SENSE_W-1:0] sense_flat;
   logic [SENSE_W-1:0] sense_q;
   logic [NUM_CH-1:0] level;
   logic [NUM_CH-1:0] latch_reg;
   logic [NUM_CH-1:0] latch_next;
   logic [NUM_CH-1:0] armed_reg;
   logic [NUM_CH-1:0] armed_next;
   logic [NUM_CH-1:0] cond_q_reg;
   logic [NUM_CH-1:0] mismatch;
   logic [NUM_CH-1:0] change_evt;
   logic [NUM_CH-1:0] latch_take;
   logic [NUM_CH-1:0] flag_reg;
   logic [NUM_CH-1:0] flag_next;
   logic [NUM_CH-1:0] flag_clr;
   logic [NUM_CH-1:0] seen_reg;
   logic [NUM_CH-1:0] seen_next;

   // interrupt status and mask
   logic [NUM_CH-1:0] status_reg;
   logic [NUM_CH-1:0] status_next;
   logic [NUM_CH-1:0] mask_reg;
   logic [NUM_CH-1:0] mask_next;
   logic              irq_reg;
   logic              irq_next;
   logic [7:0]        result_byte;

   // one wait state: reads captured on the first edge, writes taken on the second
   assign req          = bus_req.read | bus_req.write;
   assign waitreq_next = ~(req & waitreq_reg);
   assign done         = req & ~waitreq_reg;
   assign rd_take      = bus_req.read & waitreq_reg;
   assign wr_done      = bus_req.write & done;
   assign lane0        = bus_req.byteenable[0];

   assign hit_ctrl0  = bus_req.address == ADDR_CTRL0;
   assign hit_ctrl1  = bus_req.address == ADDR_CTRL1;
   assign hit_result = bus_req.address == ADDR_RESULT;
   assign hit_status = bus_req.address == ADDR_STATUS;
   assign hit_mask   = bus_req.address == ADDR_MASK;

   // result read covers the whole request so events are held off throughout
   assign rd_result  = bus_req.read & hit_result;
   assign rd_status  = rd_take & hit_status;
   assign wr_result  = wr_done & lane0 & hit_result;
   assign wr_mask    = wr_done & lane0 & hit_mask;
   assign wr_ctrl[0] = wr_done & lane0 & hit_ctrl0;
   assign wr_ctrl[1] = wr_done & lane0 & hit_ctrl1;

   assign result_byte = {2'h0, flag_reg, 2'h0, level};

   // unmapped addresses read zero and ignore writes
   always_comb
   begin
      rd_mux = READ_IDLE;
      if (hit_ctrl0)
         rd_mux = {24'h0, ctrl_reg[0]};
      else if (hit_ctrl1)
         rd_mux = {24'h0, ctrl_reg[1]};
      else if (hit_result)
         rd_mux = {24'h0, result_byte};
      else if (hit_status)
         rd_mux = {30'h0, status_reg};
      else if (hit_mask)
         rd_mux = {30'h0, mask_reg};
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         waitreq_reg  <= 1'b1;
         readdata_reg <= READ_IDLE;
      end
      else
      begin
         waitreq_reg <= waitreq_next;
         if (rd_take)
            readdata_reg <= rd_mux;
      end
   end

   // front-end decisions cross into mclk before anything reads them
   assign sense_flat = sense_raw;

   sync2 #(
      .W (SENSE_W)
   ) u_sense_sync (
      .mclk (mclk),
      .srst (srst),
      .d    (sense_flat),
      .q    (sense_q)
   );

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++)
      begin : g_ch
         assign sense_sync[c] = sense_q[c*$bits(afe_sense_t) +: $bits(afe_sense_t)];
         assign code_w[c]     = ctrl_reg[c].code;

         // each channel has its own comparator logic and control register
         vcomp_channel u_chan (
            .mclk        (mclk),
            .srst        (srst),
            .ctrl        (ctrl_reg[c]),
            .sense       (sense_sync[c]),
            .level_above (level[c])
         );

         assign ctrl_next[c] = wr_ctrl[c] ? ctrl_t'(bus_req.writedata[7:0]) : ctrl_reg[c];

         // the external reference leaves the code unused by the channel
         assign afe_next[c] = '{run:       ctrl_reg[c].run,
                                ref_ext:   ctrl_reg[c].ref_ext,
                                hyst:      ctrl_reg[c].hyst & ~ctrl_reg[c].ref_ext,
                                upper_num: NUM_W'(UPPER_BASE + NUM_W'(code_w[c])),
                                lower_num: NUM_W'(LOWER_BASE + NUM_W'(code_w[c]))};

         // a result read with run and enable set snapshots the live level
         assign latch_take[c] = rd_take & hit_result & ctrl_reg[c].run
                                & ctrl_reg[c].irq_en;
         assign latch_next[c] = latch_take[c] ? level[c] : latch_reg[c];
         assign armed_next[c] = ctrl_reg[c].run & ctrl_reg[c].irq_en
                                & (latch_take[c] | armed_reg[c]);

         // edge of the difference, so a held difference raises one event
         assign mismatch[c]   = armed_reg[c] & (level[c] != latch_reg[c])
                                & ~rd_result;
         assign change_evt[c] = mismatch[c] & ~cond_q_reg[c] & ctrl_reg[c].irq_en;

         // clear needs a read showing one, then a write of zero; set wins
         assign seen_next[c] = (rd_take & hit_result & flag_reg[c]) ? 1'b1 :
                               wr_result ? 1'b0 : seen_reg[c];
         assign flag_clr[c]  = wr_result & seen_reg[c] & ~bus_req.writedata[FLAG_LSB + c];
         assign flag_next[c] = change_evt[c] | (flag_reg[c] & ~flag_clr[c]);

         assign status_next[c] = change_evt[c] | (status_reg[c] & ~rd_status);
         assign mask_next[c]   = wr_mask ? bus_req.writedata[c] : mask_reg[c];

         always_ff @(posedge mclk)
         begin
            if (srst)
            begin
               ctrl_reg[c] <= ctrl_t'(CTRL_RESET);
               afe_reg[c]  <= '0;
            end
            else
            begin
               ctrl_reg[c] <= ctrl_next[c];
               afe_reg[c]  <= afe_next[c];
            end
         end

         always_ff @(posedge mclk)
         begin
            if (srst)
            begin
               latch_reg[c]  <= 1'b0;
               armed_reg[c]  <= 1'b0;
               cond_q_reg[c] <= 1'b0;
               flag_reg[c]   <= 1'b0;
               seen_reg[c]   <= 1'b0;
               status_reg[c] <= 1'b0;
               mask_reg[c]   <= 1'b0;
            end
            else
            begin
               latch_reg[c]  <= latch_next[c];
               armed_reg[c]  <= armed_next[c];
               cond_q_reg[c] <= mismatch[c];
               flag_reg[c]   <= flag_next[c];
               seen_reg[c]   <= seen_next[c];
               status_reg[c] <= status_next[c];
               mask_reg[c]   <= mask_next[c];
            end
         end

         assign afe_ctrl[c] = afe_reg[c];

         sequence s_read_one;
            rd_take && hit_result && flag_reg[c] && !change_evt[c];
         endsequence

         sequence s_write_zero;
            wr_result && !bus_req.writedata[FLAG_LSB + c] && !change_evt[c];
         endsequence

         // read capture to write landing: read, idle, write request, write lands
         a_flag_clear: assert property (
            @(posedge mclk) disable iff (srst)
            s_read_one ##1 (!wr_result) [*3] ##1 s_write_zero |=> !flag_reg[c])
            else $error("change flag survived read-one then write-zero");

         a_flag_write1: assert property (
            @(posedge mclk) disable iff (srst)
            flag_reg[c] && wr_result && bus_req.writedata[FLAG_LSB + c] |=> flag_reg[c])
            else $error("writing one cleared a change flag");

         a_irq_gate: assert property (
            @(posedge mclk) disable iff (srst)
            !ctrl_reg[c].irq_en |-> !change_evt[c] ##1 !armed_reg[c])
            else $error("disabled channel armed or raised an event");

         a_read_mask: assert property (
            @(posedge mclk) disable iff (srst)
            rd_result |-> !change_evt[c])
            else $error("event raised during a result read");

         a_change_flag: assert property (
            @(posedge mclk) disable iff (srst)
            armed_reg[c] && ctrl_reg[c].irq_en && !rd_result && !cond_q_reg[c]
            && level[c] != latch_reg[c] |=> flag_reg[c] && status_reg[c])
            else $error("difference from latched level raised no flag");

         a_latch_take: assert property (
            @(posedge mclk) disable iff (srst)
            latch_take[c] |=> armed_reg[c] && latch_reg[c] == $past(level[c]))
            else $error("result read did not snapshot the level");

         a_upper_code: assert property (
            @(posedge mclk) disable iff (srst)
            !$past(srst) |-> afe_reg[c].upper_num == NUM_W'(UPPER_BASE + $past(code_w[c]))
            && afe_reg[c].lower_num == NUM_W'(LOWER_BASE + $past(code_w[c])))
            else $error("reference numerators do not match the code");
      end
   endgenerate

   // level interrupt, one cycle behind the status bits
   assign irq_next = |(status_reg & mask_reg);

   always_ff @(posedge mclk)
   begin
      if (srst)
         irq_reg <= 1'b0;
      else
         irq_reg <= irq_next;
   end

   assign readdata    = readdata_reg;
   assign waitrequest = waitreq_reg;
   assign irq         = irq_reg;

   a_result_read: assert property (
      @(posedge mclk) disable iff (srst)
      rd_take && hit_result |=> readdata[NUM_CH-1:0] == $past(level)
      && !waitrequest)
      else $error("result read does not return the live levels");

endmodule

// file: verif/afe_model.sv
// behavioural analog front end: two comparator pins and one reference pin
// assumes pin voltages in sixtieths of supply, driven by the bench
`timescale 1ns/1ps
module afe_model
(
   // clock
   input  wire logic                                         mclk,
   // pin voltages in sixtieths of supply
   input  wire logic [1:0][6:0]                              vin,
   input  wire logic [6:0]                                   vref,
   // device side
   input  wire vcomp_pkg::afe_ctrl_t  [vcomp_pkg::NUM_CH-1:0] afe_ctrl,
   output vcomp_pkg::afe_sense_t      [vcomp_pkg::NUM_CH-1:0] sense_raw
);
   import vcomp_pkg::*;

   logic churn;

   initial churn = 1'b0;
   always @(posedge mclk) churn <= ~churn;

   always_comb
   begin
      for (int c = 0; c < NUM_CH; c++)
      begin
         // levels doubled into sixtieths; equal counts as not above
         sense_raw[c].above_upper = vin[c] > {1'b0, afe_ctrl[c].upper_num, 1'b0};
         sense_raw[c].above_lower = vin[c] > {1'b0, afe_ctrl[c].lower_num, 1'b0};
         sense_raw[c].above_ext   = vin[c] > vref;
         // a halted comparator gives no usable decision
         if (!afe_ctrl[c].run)
            sense_raw[c] = {3{churn}};
      end
   end
endmodule

// file: verif/test_dual_voltage_comparator_ctrl.sv
// self-checking bench for the dual comparator control block
// assumes the behavioural front end model and an Avalon-MM master task
`timescale 1ns/1ps
module test_dual_voltage_comparator_ctrl;
   import vcomp_pkg::*;

   logic                    mclk;
   logic                    srst;
   avs_req_t                bus_req;
   logic [DATA_W-1:0]       readdata;
   logic                    waitrequest;
   logic                    irq;
   afe_sense_t [NUM_CH-1:0] sense_raw;
   afe_ctrl_t  [NUM_CH-1:0] afe_ctrl;
   logic [1:0][6:0]         vin;
   logic [6:0]              vref;
   int                      miscompares;
   int                      n_compared;

   dual_voltage_comparator_ctrl DUT (.mclk(mclk), .srst(srst), .bus_req(bus_req),
      .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
      .sense_raw(sense_raw), .afe_ctrl(afe_ctrl));
   afe_model partner (.mclk(mclk), .vin(vin), .vref(vref), .afe_ctrl(afe_ctrl),
      .sense_raw(sense_raw));

   task automatic finish_test();
      if (miscompares == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   // one transfer; an extra edge after release keeps drivers one per time step
   task automatic bus_xfer(input logic wr, input logic [ADDR_W-1:0] a,
                           input logic [7:0] d, output logic [DATA_W-1:0] q,
                           input logic [3:0] be = 4'hf);
      int n;
      n = 0;
      bus_req.address    <= a;
      bus_req.read       <= !wr;
      bus_req.write      <= wr;
      bus_req.writedata  <= {24'h0, d};
      bus_req.byteenable <= be;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (waitrequest !== 1'b0);
      q = readdata;
      // one wait state: the answer is seen at the second edge
      check("handshake edges", 32'h2, 32'(n));
      bus_req.read  <= 1'b0;
      bus_req.write <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [DATA_W-1:0] q;
      bus_xfer(1'b1, a, d, q);
      // control outputs launch on the extra edge after release; sample them one edge later
      @(posedge mclk);
   endtask

   task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] e);
      logic [DATA_W-1:0] q;
      bus_xfer(1'b0, a, 8'h00, q);
      check(what, {24'h0, e}, q);
   endtask

   task automatic set_pin(input int c, input logic [6:0] v);
      vin[c] <= v;
      repeat (8) @(posedge mclk);
   endtask

   task automatic t_reset();
      logic [DATA_W-1:0] q;
      check("afe_ctrl", 32'h0, {6'h0, afe_ctrl});
      check("irq", 32'h0, 32'(irq));
      rd_chk("ctrl0", ADDR_CTRL0, 8'h00);
      rd_chk("ctrl1", ADDR_CTRL1, 8'h00);
      rd_chk("mask", ADDR_MASK, 8'h00);
      wr(5'h14, 8'hff);
      rd_chk("unmapped", 5'h14, 8'h00);
      bus_xfer(1'b1, ADDR_CTRL0, 8'hff, q, 4'he);
      rd_chk("lane0 off", ADDR_CTRL0, 8'h00);
      wr(ADDR_CTRL1, 8'h5a);
      rd_chk("ctrl1 rw", ADDR_CTRL1, 8'h5a);
      rd_chk("ctrl0 apart", ADDR_CTRL0, 8'h00);
      wr(ADDR_CTRL1, 8'h00);
   endtask

   task automatic t_codes();
      for (int c = 0; c < 2; c++)
         for (int n = 0; n < 16; n++)
         begin
            wr(c ? ADDR_CTRL1 : ADDR_CTRL0, {4'h8, 4'(n)});
            check("run", 32'h1, 32'(afe_ctrl[c].run));
            check("upper_num", 11 + n, 32'(afe_ctrl[c].upper_num));
            check("lower_num", 9 + n, 32'(afe_ctrl[c].lower_num));
            set_pin(c, 7'(2 * (11 + n) + 1));
            rd_chk("above", ADDR_RESULT, 8'(1 << c));
            set_pin(c, 7'(2 * (11 + n)));
            rd_chk("at level", ADDR_RESULT, 8'h00);
         end
   endtask

   task automatic t_hyst();
      logic [6:0] v [5] = '{7'd20, 7'd30, 7'd33, 7'd30, 7'd28};
      logic [7:0] e [5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
      wr(ADDR_CTRL0, 8'h95);
      check("hyst", 32'h1, 32'(afe_ctrl[0].hyst));
      for (int i = 0; i < 5; i++)
      begin
         set_pin(0, v[i]);
         rd_chk("hysteresis", ADDR_RESULT, e[i]);
      end
   endtask

   task automatic t_ext();
      vref <= 7'd50;
      wr(ADDR_CTRL0, 8'ha0);
      wr(ADDR_CTRL1, 8'h80);
      check("ref_ext0", 32'h1, 32'(afe_ctrl[0].ref_ext));
      check("ref_ext1", 32'h0, 32'(afe_ctrl[1].ref_ext));
      set_pin(1, 7'd23);
      // internal code 0 would call this pin high
      set_pin(0, 7'd45);
      rd_chk("ext low", ADDR_RESULT, 8'h02);
      wr(ADDR_CTRL0, 8'haf);
      set_pin(0, 7'd51);
      rd_chk("ext high", ADDR_RESULT, 8'h03);
      set_pin(0, 7'd50);
      rd_chk("ext equal", ADDR_RESULT, 8'h02);
      wr(ADDR_RESULT, 8'h03);
      rd_chk("result ro", ADDR_RESULT, 8'h02);
      wr(ADDR_CTRL1, 8'h00);
      rd_chk("halted", ADDR_RESULT, 8'h00);
   endtask

   task automatic t_irq();
      wr(ADDR_CTRL1, 8'hc0);
      set_pin(1, 7'd10);
      rd_chk("arm", ADDR_RESULT, 8'h00);
      set_pin(1, 7'd30);
      check("irq masked", 32'h0, 32'(irq));
      rd_chk("status", ADDR_STATUS, 8'h02);
      rd_chk("status clr", ADDR_STATUS, 8'h00);
      rd_chk("flag", ADDR_RESULT, 8'h22);
      wr(ADDR_RESULT, 8'h20);
      rd_chk("flag kept", ADDR_RESULT, 8'h22);
      wr(ADDR_RESULT, 8'h00);
      rd_chk("flag clr", ADDR_RESULT, 8'h02);
      wr(ADDR_MASK, 8'h02);
      rd_chk("mask rw", ADDR_MASK, 8'h02);
      set_pin(1, 7'd10);
      check("irq", 32'h1, 32'(irq));
      rd_chk("status 2", ADDR_STATUS, 8'h02);
      repeat (2) @(posedge mclk);
      check("irq low", 32'h0, 32'(irq));
      rd_chk("flag again", ADDR_RESULT, 8'h20);
      wr(ADDR_RESULT, 8'h00);
      // enable off must disarm the latch as well
      wr(ADDR_CTRL1, 8'h80);
      set_pin(1, 7'd30);
      rd_chk("disarmed", ADDR_STATUS, 8'h00);
      check("irq off", 32'h0, 32'(irq));
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      finish_test();
   end

   initial
   begin
      srst        = 1'b1;
      bus_req     = '0;
      vin         = '0;
      vref        = '0;
      miscompares = 0;
      n_compared  = 0;
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_codes();
      t_hyst();
      t_ext();
      t_irq();
      finish_test();
   end
endmodule
